// ===== hdl/adcsq_defs.vh
// register offsets, field positions and timing constants of the converter sequencer
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH
`define ADCSQ_OFF_SETUP 8'h00
`define ADCSQ_OFF_RESULT 8'h02
`define ADCSQ_OFF_STATE 8'h04
`define ADCSQ_OFF_TRIGGER 8'h06
`define ADCSQ_OFF_IRQ 8'h08
`define ADCSQ_OFF_SEQCTL 8'h0A
`define ADCSQ_OFF_SEQSTATE 8'h0C
`define ADCSQ_OFF_SEQINT 8'h0E
`define ADCSQ_OFF_INSTR 8'h80
`define ADCSQ_OFF_DATA 8'hC0
`define ADCSQ_RESET_VALUE 16'h0000
`define ADCSQ_SETUP_MASK 16'h07FF
`define ADCSQ_BIT_AUTO 8
`define ADCSQ_BIT_PIPE 9
`define ADCSQ_BIT_IRQEN 10
`define ADCSQ_BIT_SEQEN 0
`define ADCSQ_BIT_SEQ_INTERVAL 1
`define ADCSQ_CLK_MHZ 25
// times in nanoseconds
`define ADCSQ_T_NORM_PIPE_NS 12500
`define ADCSQ_T_NORM_NOPIPE_NS 20000
`define ADCSQ_T_AUTO_PIPE_NS 20000
`define ADCSQ_T_AUTO_NOPIPE_NS 30000
`define ADCSQ_T_SEQ_OVH_NS 12000
`define ADCSQ_T_SEQ_CH_NS 12500
`define ADCSQ_T_TICK_NS 100000
`define ADCSQ_CYC(ns) (((ns) * `ADCSQ_CLK_MHZ) / 1000)
`endif

// ===== hdl/adcsq_top.v
// converter control, sequencer and local register window
`timescale 1ns/1ps
`include "adcsq_defs.vh"
module adcsq_top #(
    parameter CHANNELS = 32,
    parameter TICK_CYCLES = `ADCSQ_CYC(`ADCSQ_T_TICK_NS)
) (
    input wire CLOCK,
    input wire RST_B,
    input wire [7:0] ADDR,
    input wire WR,
    input wire RD,
    input wire [15:0] WDATA,
    output reg [15:0] RDATA,
    input wire [15:0] ADC_SAMPLE,
    output reg [4:0] ADC_CHANNEL,
    output reg [1:0] ADC_GAIN,
    output reg ADC_START,
    output reg IRQ
);
localparam [15:0] C_SETTLE = `ADCSQ_CYC(`ADCSQ_T_SEQ_OVH_NS);
localparam [15:0] C_NP = `ADCSQ_CYC(`ADCSQ_T_NORM_PIPE_NS);
localparam [15:0] C_NN = `ADCSQ_CYC(`ADCSQ_T_NORM_NOPIPE_NS);
localparam [15:0] C_AP = `ADCSQ_CYC(`ADCSQ_T_AUTO_PIPE_NS);
localparam [15:0] C_AN = `ADCSQ_CYC(`ADCSQ_T_AUTO_NOPIPE_NS);
localparam [15:0] C_CH = `ADCSQ_CYC(`ADCSQ_T_SEQ_CH_NS);
localparam [15:0] C_OVH = `ADCSQ_CYC(`ADCSQ_T_SEQ_OVH_NS);
localparam [4:0] S_IDLE = 5'h01;
localparam [4:0] S_SETTLE = 5'h02;
localparam [4:0] S_WAIT = 5'h04;
localparam [4:0] S_CONV = 5'h08;
localparam [4:0] S_SEQ = 5'h10;

reg [15:0] setup;
reg [15:0] result;
reg [15:0] pipe_hold;
reg [15:0] irq_flags;
reg [15:0] seq_control;
reg [15:0] seq_state;
reg [15:0] seq_interval;
reg [15:0] instr_mem [0:CHANNELS-1];
reg [15:0] data_mem [0:2*CHANNELS-1];
reg [4:0] state;
reg [15:0] count;
reg [4:0] seq_ch;
reg seq_sel;
reg conv_busy;
reg [15:0] tick_cnt;
reg [15:0] interval_cnt;
reg seq_pending;
wire [15:0] conv_cycles;
wire wr_setup;
wire wr_trigger;
wire seq_on;
wire seq_tick;
integer i;

assign seq_on = seq_control[`ADCSQ_BIT_SEQEN];
assign wr_setup = WR && ADDR == `ADCSQ_OFF_SETUP && !seq_on;
assign wr_trigger = WR && ADDR == `ADCSQ_OFF_TRIGGER;
// conversion window picked by mode and pipelining
assign conv_cycles = setup[`ADCSQ_BIT_AUTO] ? (setup[`ADCSQ_BIT_PIPE] ? C_AP : C_AN)
    : (setup[`ADCSQ_BIT_PIPE] ? C_NP : C_NN);
assign seq_tick = tick_cnt == TICK_CYCLES[15:0] - 16'h0001;

////////////////////////////////////////////////////////////////////////////////
// timer base and interval pacing
always @(posedge CLOCK)
begin
    if (!RST_B)
    begin
        tick_cnt <= 16'h0000;
        interval_cnt <= 16'h0000;
        seq_pending <= 1'b0;
    end
    else
    begin
        tick_cnt <= seq_tick ? 16'h0000 : tick_cnt + 16'h0001;
        if (!seq_on || !seq_control[`ADCSQ_BIT_SEQ_INTERVAL])
        begin
            interval_cnt <= 16'h0000;
            seq_pending <= 1'b0;
        end
        else if (seq_tick)
        begin
            // a zero interval never fires, the smallest usable step is one tick
            if (seq_interval != 16'h0000 && interval_cnt + 16'h0001 >= seq_interval)
            begin
                interval_cnt <= 16'h0000;
                seq_pending <= 1'b1;
            end
            else
                interval_cnt <= interval_cnt + 16'h0001;
        end
        // a start that lands while a pass runs is dropped, except in the pass's last cycle, where it starts the next pass at once
        else if (state == S_SEQ)
            seq_pending <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registers, conversion and sequencer control
always @(posedge CLOCK)
begin
    if (!RST_B)
    begin
        setup <= `ADCSQ_RESET_VALUE;
        result <= `ADCSQ_RESET_VALUE;
        pipe_hold <= `ADCSQ_RESET_VALUE;
        irq_flags <= `ADCSQ_RESET_VALUE;
        seq_control <= `ADCSQ_RESET_VALUE;
        seq_state <= `ADCSQ_RESET_VALUE;
        seq_interval <= `ADCSQ_RESET_VALUE;
        state <= S_IDLE;
        count <= 16'h0000;
        seq_ch <= 5'h00;
        seq_sel <= 1'b0;
        conv_busy <= 1'b0;
        ADC_CHANNEL <= 5'h00;
        ADC_GAIN <= 2'h0;
        ADC_START <= 1'b0;
        IRQ <= 1'b0;
        for (i = 0; i < CHANNELS; i = i + 1)
            instr_mem[i] <= `ADCSQ_RESET_VALUE;
        for (i = 0; i < 2 * CHANNELS; i = i + 1)
            data_mem[i] <= `ADCSQ_RESET_VALUE;
    end
    else
    begin
        ADC_START <= 1'b0;
        if (WR && ADDR == `ADCSQ_OFF_IRQ)
            irq_flags <= irq_flags & ~WDATA;
        if (WR && ADDR == `ADCSQ_OFF_SEQCTL)
            seq_control <= WDATA;
        if (WR && ADDR == `ADCSQ_OFF_SEQSTATE)
            seq_state <= seq_state & ~WDATA;
        if (WR && ADDR == `ADCSQ_OFF_SEQINT)
            seq_interval <= WDATA;
        if (WR && ADDR[7:6] == 2'b10 && !ADDR[0])
            instr_mem[ADDR[5:1]] <= WDATA;
        if (wr_setup)
        begin
            setup <= WDATA & `ADCSQ_SETUP_MASK;
            ADC_CHANNEL <= WDATA[4:0];
            ADC_GAIN <= WDATA[7:6];
        end
        case (state)
        S_IDLE:
        begin
            if (wr_setup)
            begin
                state <= S_SETTLE;
                count <= C_SETTLE;
            end
            else if (wr_trigger && !seq_on)
            begin
                state <= S_CONV;
                count <= conv_cycles;
                ADC_START <= 1'b1;
                if (setup[`ADCSQ_BIT_PIPE])
                    result <= pipe_hold;
            end
            else if (seq_on && (!seq_control[`ADCSQ_BIT_SEQ_INTERVAL] || seq_pending))
            begin
                state <= S_SEQ;
                // one cycle per visited channel is folded into the fixed overhead
                count <= C_OVH - CHANNELS[15:0];
                seq_ch <= 5'h00;
                conv_busy <= 1'b0;
                seq_state[0] <= 1'b1;
            end
        end
        S_SETTLE:
        begin
            if (count <= 16'h0001)
            begin
                if (setup[`ADCSQ_BIT_AUTO])
                begin
                    state <= S_CONV;
                    count <= conv_cycles;
                    ADC_START <= 1'b1;
                    if (setup[`ADCSQ_BIT_PIPE])
                        result <= pipe_hold;
                end
                else
                begin
                    state <= S_IDLE;
                    irq_flags[0] <= 1'b1;
                end
            end
            else
                count <= count - 16'h0001;
        end
        S_CONV:
        begin
            if (count <= 16'h0001)
            begin
                state <= S_IDLE;
                pipe_hold <= ADC_SAMPLE;
                if (!setup[`ADCSQ_BIT_PIPE])
                    result <= ADC_SAMPLE;
                irq_flags[1] <= 1'b1;
            end
            else
                count <= count - 16'h0001;
        end
        S_SEQ:
        begin
            if (count > 16'h0001)
                count <= count - 16'h0001;
            else if (!seq_on)
            begin
                state <= S_IDLE;
                seq_state[0] <= 1'b0;
                conv_busy <= 1'b0;
            end
            else if (!conv_busy && instr_mem[seq_ch][3:0] != 4'h0)
            begin
                ADC_CHANNEL <= seq_ch;
                ADC_GAIN <= instr_mem[seq_ch][2:1];
                ADC_START <= 1'b1;
                conv_busy <= 1'b1;
                count <= C_CH - 16'h0001;
            end
            else
            begin
                // the sample is stored at the slot end, after the new channel has been converted
                if (conv_busy)
                    data_mem[{seq_ch, seq_sel}] <= ADC_SAMPLE;
                conv_busy <= 1'b0;
                count <= 16'h0001;
                if (seq_ch == CHANNELS[4:0] - 5'h01)
                begin
                    seq_ch <= 5'h00;
                    seq_sel <= ~seq_sel;
                    state <= S_IDLE;
                    seq_state[0] <= 1'b0;
                    seq_state[1] <= 1'b1;
                end
                else
                    seq_ch <= seq_ch + 5'h01;
            end
        end
        default:
            state <= S_IDLE;
        endcase
        IRQ <= setup[`ADCSQ_BIT_IRQEN] && (irq_flags[1] || (!setup[`ADCSQ_BIT_AUTO] && irq_flags[0]));
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path, offsets are relative to the bridge window base
always @(posedge CLOCK)
begin
    if (!RST_B)
        RDATA <= 16'h0000;
    else if (RD)
    begin
        if (ADDR == `ADCSQ_OFF_SETUP)
            RDATA <= setup;
        else if (ADDR == `ADCSQ_OFF_RESULT)
            RDATA <= result;
        else if (ADDR == `ADCSQ_OFF_STATE)
            RDATA <= {14'h0000, state == S_CONV, state == S_SETTLE};
        else if (ADDR == `ADCSQ_OFF_IRQ)
            RDATA <= irq_flags;
        else if (ADDR == `ADCSQ_OFF_SEQCTL)
            RDATA <= seq_control;
        else if (ADDR == `ADCSQ_OFF_SEQSTATE)
            RDATA <= seq_state;
        else if (ADDR == `ADCSQ_OFF_SEQINT)
            RDATA <= seq_interval;
        else if (ADDR[7:6] == 2'b10)
            RDATA <= instr_mem[ADDR[5:1]];
        else if (ADDR[7:6] == 2'b11)
            RDATA <= data_mem[{ADDR[5:1], ~seq_sel}];
        else
            RDATA <= 16'h0000;
    end
end
endmodule // adcsq_top

// ===== verif/adcsq_bridge.sv
// local bus side of the bridge: one-cycle register strobes
`timescale 1ns/1ps
module adcsq_bridge (
    input wire clock,
    output reg [7:0] addr,
    output reg wr,
    output reg rd,
    output reg [15:0] wdata,
    input wire [15:0] rdata
);
initial
begin
    addr = 8'hFF;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'hFFFF;
end
// hosts send window offsets only, the base is applied upstream
task put(input [7:0] a, input [15:0] d);
begin
    @(negedge clock);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
    // released lines invert so a stale value cannot pass
    addr = ~a;
    wdata = ~d;
end
endtask
task get(input [7:0] a, output [15:0] q);
begin
    @(negedge clock);
    addr = a;
    rd = 1'b1;
    @(negedge clock);
    rd = 1'b0;
    addr = ~a;
    q = rdata;
end
endtask
endmodule // adcsq_bridge

// ===== verif/adcsq_checker.sv
// port assertions for the converter sequencer
`timescale 1ns/1ps
module adcsq_checker (
    input wire CLOCK,
    input wire RST_B,
    input wire [7:0] ADDR,
    input wire WR,
    input wire RD,
    input wire [15:0] WDATA,
    input wire [15:0] RDATA,
    input wire [15:0] ADC_SAMPLE,
    input wire [4:0] ADC_CHANNEL,
    input wire [1:0] ADC_GAIN,
    input wire ADC_START,
    input wire IRQ
);
reg seq_on;
reg [2:0] cfg;
reg [9:0] cnt;
wire wr_set = WR && ADDR == 8'h00 && !seq_on;
// three cycles of slack cover result load, flag and registered irq
wire [9:0] lim = cfg[0] ? (cfg[1] ? 10'h1F7 : 10'h2F1) : (cfg[1] ? 10'h13B : 10'h1F7);
always @(posedge CLOCK)
begin
    if (!RST_B || !cfg[2] || seq_on || IRQ)
        cnt <= 10'h000;
    else if (ADC_START || cnt != 10'h000)
        cnt <= cnt + 10'h001;
    if (!RST_B)
        seq_on <= 1'b0;
    else if (WR && ADDR == 8'h0A)
        seq_on <= WDATA[0];
    if (!RST_B)
        cfg <= 3'h0;
    else if (wr_set)
        cfg <= WDATA[10:8];
end
////////////////////////////////////////
default clocking @(posedge CLOCK); endclocking
default disable iff (!RST_B);
property p_rst; disable iff (1'b0) !RST_B |=> RDATA == 16'h0000 && !IRQ && !ADC_START; endproperty
a_rst: assert property (p_rst) else $error("reset left outputs set");
property p_pulse; ADC_START |=> !ADC_START; endproperty
a_pulse: assert property (p_pulse) else $error("start pulse too long");
property p_hole; RD && ADDR >= 8'h10 && ADDR < 8'h80 |=> RDATA == 16'h0000; endproperty
a_hole: assert property (p_hole) else $error("reserved read not zero");
property p_hold; !RD |=> $stable(RDATA); endproperty
a_hold: assert property (p_hold) else $error("read data moved");
property p_auto; wr_set && WDATA[8] && !IRQ |-> !IRQ throughout (##[1:305] ADC_START); endproperty
a_auto: assert property (p_auto) else $error("auto start missing");
property p_norm; wr_set && WDATA[10] && !WDATA[8] |-> !ADC_START throughout (##[1:305] IRQ); endproperty
a_norm: assert property (p_norm) else $error("settle irq missing");
property p_time; cnt != 10'h000 |-> cnt <= lim; endproperty
a_time: assert property (p_time) else $error("conversion too slow");
property p_gate; !cfg[2] ##1 !cfg[2] |-> !IRQ; endproperty
a_gate: assert property (p_gate) else $error("irq while disabled");
c_start: cover property (ADC_START);
c_irq: cover property ($rose(IRQ));
c_hole: cover property (RD && ADDR == 8'h10);
endmodule // adcsq_checker

// ===== verif/tb.sv
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module tb;
reg CLOCK = 1'b0;
reg RST_B = 1'b0;
wire [7:0] ADDR;
wire WR, RD, ADC_START, IRQ;
wire [15:0] WDATA, RDATA, ADC_SAMPLE;
wire [4:0] ADC_CHANNEL;
wire [1:0] ADC_GAIN;
integer miscompares = 0;
integer num_checks = 0;
integer i;
reg [15:0] v;
always #20 CLOCK = ~CLOCK;
// sample carries the channel so a result shows where it came from
assign ADC_SAMPLE = {11'h2A5, ADC_CHANNEL};
adcsq_top #(.TICK_CYCLES(10)) u_adcsq_top (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WR(WR), .RD(RD),
    .WDATA(WDATA), .RDATA(RDATA), .ADC_SAMPLE(ADC_SAMPLE), .ADC_CHANNEL(ADC_CHANNEL), .ADC_GAIN(ADC_GAIN),
    .ADC_START(ADC_START), .IRQ(IRQ));
adcsq_bridge u_bridge (.clock(CLOCK), .addr(ADDR), .wr(WR), .rd(RD), .wdata(WDATA), .rdata(RDATA));
task chk(input [63:0] nm, input [15:0] e, input [15:0] s);
begin
    num_checks = num_checks + 1;
    if (s !== e)
    begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, s);
    end
end
endtask
task rdc(input [63:0] nm, input [7:0] a, input [15:0] e);
begin
    u_bridge.get(a, v);
    chk(nm, e, v);
end
endtask
task wrap_up;
begin
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
end
endtask
////////////////////////////////////////
task t_reset;
begin
    for (i = 0; i < 9; i = i + 1)
        rdc("reset", {i[6:0], 1'b0}, 16'h0000);
    rdc("instr", 8'h80, 16'h0000);
    rdc("data", 8'hC0, 16'h0000);
end
endtask
// m[0] automatic settling, m[1] pipelining; always channel 7 with irq on
task t_conv(input [1:0] m);
integer n;
begin
    u_bridge.put(8'h00, {5'h00, 1'b1, m[1], m[0], 8'h07});
    if (!m[0])
    begin
        for (n = 0; n < 400 && IRQ !== 1'b1; n = n + 1) @(negedge CLOCK);
        chk("setlirq", 16'h0001, {15'h0000, IRQ});
        rdc("settled", 8'h04, 16'h0000);
        u_bridge.put(8'h08, 16'h0001);
        u_bridge.put(8'h06, 16'h0001);
    end
    for (n = 0; n < 400 && ADC_START !== 1'b1; n = n + 1) @(negedge CLOCK);
    for (n = 0; n < 800 && IRQ !== 1'b1; n = n + 1) @(negedge CLOCK);
    chk("convtime", 16'h0001, {15'h0000, n <= (m == 2'h2 ? 315 : m == 2'h1 ? 753 : 503)});
    rdc("result", 8'h02, {11'h2A5, 5'h07});
    u_bridge.get(8'h08, v);
    chk("flags", 16'h0002, v & 16'h0002);
    u_bridge.put(8'h08, 16'h0003);
    @(negedge CLOCK);
    chk("irqclr", 16'h0000, {15'h0000, IRQ});
end
endtask
task t_block;
begin
    u_bridge.put(8'h0A, 16'h0001);
    u_bridge.put(8'h00, 16'h0000);
    rdc("setup", 8'h00, 16'h0707);
    u_bridge.put(8'h0A, 16'h0000);
    u_bridge.put(8'h82, 16'h0003);
    rdc("instr", 8'h82, 16'h0003);
    u_bridge.put(8'hC4, 16'hFFFF);
    rdc("dataro", 8'hC4, 16'h0000);
end
endtask
task t_seq;
integer n;
begin
    u_bridge.put(8'h00, 16'h0000);
    repeat (310) @(negedge CLOCK);
    u_bridge.put(8'h84, 16'h0001);
    u_bridge.put(8'h0A, 16'h0001);
    v = 16'h0000;
    for (n = 0; n < 600 && v[1] !== 1'b1; n = n + 1) u_bridge.get(8'h0C, v);
    chk("passtime", 16'h0001, {15'h0000, 2 * n <= 300 + 2 * 312 + 8});
    u_bridge.put(8'h0A, 16'h0000);
    rdc("seqch1", 8'hC2, {11'h2A5, 5'h01});
    rdc("seqch2", 8'hC4, {11'h2A5, 5'h02});
end
endtask
initial
begin
    #2000000;
    miscompares = miscompares + 1;
    wrap_up;
end
initial
begin
    repeat (3) @(negedge CLOCK);
    RST_B = 1'b1;
    t_reset;
    for (i = 0; i < 4; i = i + 1)
        t_conv(i[1:0]);
    t_block;
    t_seq;
    wrap_up;
end
endmodule // tb
bind adcsq_top adcsq_checker u_adcsq_checker (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WR(WR), .RD(RD),
    .WDATA(WDATA), .RDATA(RDATA), .ADC_SAMPLE(ADC_SAMPLE), .ADC_CHANNEL(ADC_CHANNEL), .ADC_GAIN(ADC_GAIN),
    .ADC_START(ADC_START), .IRQ(IRQ));
